// File: hw/secreg_cmd.v
`include "secreg_consts.vh"
// Behaviour
// - Program frame: 42H, address, data bytes
// - Programming starts when select rises
// - In-progress flag high during programming
// - Write latch cleared before programming ends
// - Lock flag blocks security-register programming
// - Four 256-byte pages, A9-A8 select page
// - Read frame: 48H, address, dummy byte
// - Output falling edge, MSB first
// - Address increments after each byte
// - Byte address wraps FFH to 00H
// - Reset needs 66H frame then 99H frame
// - Reset clears volatile state, aborts operation
// - No command accepted during reset recovery
// - 5AH returns signature 50444653H LSB first
// - Header bytes 04H-06H: 06H, 01H, 01H
// - First header: ID 00H, 1.06, 09H, 30H
// - Second header: 1.00, 03H, 60H
// - Unused header bytes read FFH
module secreg_cmd #(
  parameter [23:0] PROG_CYCLES = `PAGE_PROG_CYC,
  parameter [7:0]  VENDOR_ID   = 8'h5a  // Arbitrary value
) (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       sel_n,
  input  wire       sclk,
  input  wire       serial_in_line,
  output reg        serial_out,
  output reg        serial_out_oe,
  input  wire       secreg_lock_flag,
  output reg        write_latch_flag,
  output wire       op_in_progress_flag,
  output reg        suspend_flag,
  output reg  [7:0] read_param_bits,
  output reg  [7:0] continuous_read_bits,
  output reg  [2:0] wrap_bits,
  output reg        reset_busy
);
  // SKIP swallows the rest of any frame that is ignored or has no address phase
  localparam S_IDLE = 5'b00001;
  localparam S_ADDR = 5'b00010;
  localparam S_DUMY = 5'b00100;
  localparam S_DATA = 5'b01000;
  localparam S_SKIP = 5'b10000;
  localparam [23:0] RST_CYCLES = `RST_REC_CYC;

  reg  [1:0]  sel_s_r;
  reg  [1:0]  clk_s_r;
  reg  [1:0]  din_s_r;
  reg         clk_d_r;
  reg         sel_d_r;
  wire        rise;
  wire        fall;
  wire        frame_end;
  wire        selected;

  reg  [4:0]  state_r;
  reg  [7:0]  sh_r;
  reg  [2:0]  bit_r;
  reg  [7:0]  op_r;
  reg  [1:0]  abyte_r;
  reg  [1:0]  page_r;
  reg  [7:0]  addr_r;
  reg  [7:0]  obyte_r;
  reg  [2:0]  obit_r;
  reg         got_data_r;
  reg         rst_armed_r;
  reg  [23:0] timer_r;
  reg         prog_busy_r;
  reg  [7:0]  mem [0:1023];
  reg  [9:0]  wr_addr_r;
  reg  [7:0]  disc_byte;

  wire        byte_done;
  wire [7:0]  in_byte;
  wire        fifo_in_valid;
  wire [7:0]  fifo_out_data;
  wire        fifo_out_valid;
  wire        fifo_out_ready;

  always @(posedge clk_sys) begin
    if (reset) begin
      sel_s_r <= 2'b11;
      clk_s_r <= 2'b00;
      din_s_r <= 2'b00;
      clk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      sel_s_r <= {sel_s_r[0], sel_n};
      clk_s_r <= {clk_s_r[0], sclk};
      din_s_r <= {din_s_r[0], serial_in_line};
      clk_d_r <= clk_s_r[1];
      sel_d_r <= sel_s_r[1];
    end
  end

  assign selected  = ~sel_s_r[1];
  assign rise      = selected & clk_s_r[1] & ~clk_d_r;
  assign fall      = selected & ~clk_s_r[1] & clk_d_r;
  assign frame_end = sel_s_r[1] & ~sel_d_r;
  assign in_byte   = {sh_r[6:0], din_s_r[1]};
  assign byte_done = rise & (bit_r == 3'd7);
  assign op_in_progress_flag = prog_busy_r | reset_busy;

  always @* begin
    case (addr_r[4:0])
      5'h00: disc_byte = `DISC_SIG0;
      5'h01: disc_byte = `DISC_SIG1;
      5'h02: disc_byte = `DISC_SIG2;
      5'h03: disc_byte = `DISC_SIG3;
      5'h04: disc_byte = `DISC_MINOR;
      5'h05: disc_byte = `DISC_MAJOR;
      5'h06: disc_byte = `DISC_NPH;
      5'h08: disc_byte = `PH0_ID;
      5'h09: disc_byte = `PH0_MINOR;
      5'h0a: disc_byte = `PH0_MAJOR;
      5'h0b: disc_byte = `PH0_LEN;
      5'h0c: disc_byte = `PH0_PTR;
      5'h0d: disc_byte = 8'h00;
      5'h0e: disc_byte = 8'h00;
      5'h10: disc_byte = VENDOR_ID;
      5'h11: disc_byte = `PH1_MINOR;
      5'h12: disc_byte = `PH1_MAJOR;
      5'h13: disc_byte = `PH1_LEN;
      5'h14: disc_byte = `PH1_PTR;
      5'h15: disc_byte = 8'h00;
      5'h16: disc_byte = 8'h00;
      default: disc_byte = `DISC_UNUSED;
    endcase
  end

  // Data bytes queue here; the memory drains them one per cycle
  assign fifo_in_valid  = (state_r == S_DATA) & (op_r == `OP_SECREG_PROG) & byte_done &
                          write_latch_flag & ~secreg_lock_flag;
  assign fifo_out_ready = 1'b1;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (in_byte),
    .in_valid  (fifo_in_valid),
    .in_ready  (),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // Page buffer holds programmed bytes; flash AND semantics kept simple as overwrite
  always @(posedge clk_sys) begin
    if (fifo_out_valid) begin
      mem[wr_addr_r] <= fifo_out_data;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      state_r              <= S_IDLE;
      sh_r                 <= 8'h00;
      bit_r                <= 3'd0;
      op_r                 <= 8'h00;
      abyte_r              <= 2'd0;
      page_r               <= 2'd0;
      addr_r               <= 8'h00;
      obyte_r              <= 8'hff;
      obit_r               <= 3'd7;
      got_data_r           <= 1'b0;
      rst_armed_r          <= 1'b0;
      timer_r              <= 24'h00_0000;
      prog_busy_r          <= 1'b0;
      reset_busy           <= 1'b0;
      write_latch_flag     <= 1'b0;
      suspend_flag         <= 1'b0;
      read_param_bits      <= 8'h00;
      continuous_read_bits <= 8'h00;
      wrap_bits            <= 3'd0;
      wr_addr_r            <= 10'h000;
      serial_out           <= 1'b0;
      serial_out_oe        <= 1'b0;
    end else begin
      if (fifo_out_valid) begin
        wr_addr_r <= {wr_addr_r[9:8], wr_addr_r[7:0] + 8'h01};
      end
      if (timer_r != 24'h00_0000) begin
        timer_r <= timer_r - 24'h00_0001;
      end else begin
        prog_busy_r <= 1'b0;
        reset_busy  <= 1'b0;
      end
      if (prog_busy_r && timer_r == 24'h00_0002) begin
        write_latch_flag <= 1'b0;
      end
      if (rise) begin
        sh_r  <= in_byte;
        bit_r <= bit_r + 3'd1;
      end
      case (state_r)
        S_IDLE: begin
          if (byte_done) begin
            op_r    <= in_byte;
            abyte_r <= 2'd0;
            if (reset_busy) begin
              state_r <= S_SKIP;
            end else if (in_byte == `OP_SECREG_READ || in_byte == `OP_DISCOVERY ||
                         (in_byte == `OP_SECREG_PROG && !prog_busy_r)) begin
              state_r <= S_ADDR;
            end else begin
              state_r <= S_SKIP;
            end
          end
        end
        S_ADDR: begin
          if (byte_done) begin
            abyte_r <= abyte_r + 2'd1;
            if (abyte_r == 2'd1) begin
              page_r <= in_byte[1:0];
            end
            if (abyte_r == 2'd2) begin
              addr_r <= in_byte;
              if (op_r == `OP_SECREG_PROG) begin
                wr_addr_r <= {page_r, in_byte};
                state_r   <= S_DATA;
              end else begin
                state_r <= S_DUMY;
              end
            end
          end
        end
        S_DUMY: begin
          if (byte_done) begin
            obyte_r <= (op_r == `OP_DISCOVERY) ? disc_byte : mem[{page_r, addr_r}];
            obit_r  <= 3'd7;
            state_r <= S_DATA;
          end
        end
        S_DATA: begin
          if (byte_done) begin
            got_data_r <= 1'b1;
          end
          if (op_r != `OP_SECREG_PROG && fall) begin
            serial_out    <= obyte_r[obit_r];
            serial_out_oe <= 1'b1;
            obit_r        <= obit_r - 3'd1;
            if (obit_r == 3'd0) begin
              addr_r <= addr_r + 8'h01;
            end
          end
          if (op_r != `OP_SECREG_PROG && obit_r == 3'd7 && !fall) begin
            obyte_r <= (op_r == `OP_DISCOVERY) ? disc_byte : mem[{page_r, addr_r}];
          end
        end
        default: begin
        end
      endcase
      if (byte_done && state_r == S_IDLE && !reset_busy) begin
        if (in_byte == `OP_WR_LATCH_SET && !prog_busy_r) begin
          write_latch_flag <= 1'b1;
        end
      end
      if (frame_end) begin
        state_r       <= S_IDLE;
        bit_r         <= 3'd0;
        got_data_r    <= 1'b0;
        serial_out_oe <= 1'b0;
        rst_armed_r   <= 1'b0;
        if (state_r == S_DATA && op_r == `OP_SECREG_PROG && got_data_r &&
            write_latch_flag && !secreg_lock_flag) begin
          prog_busy_r <= 1'b1;
          timer_r     <= PROG_CYCLES;
        end
        if (state_r == S_SKIP && bit_r == 3'd0 && !reset_busy) begin
          if (op_r == `OP_RESET_ENABLE) begin
            rst_armed_r <= 1'b1;
          end else if (op_r == `OP_RESET && rst_armed_r) begin
            prog_busy_r          <= 1'b0;
            write_latch_flag     <= 1'b0;
            suspend_flag         <= 1'b0;
            read_param_bits      <= 8'h00;
            continuous_read_bits <= 8'h00;
            wrap_bits            <= 3'd0;
            reset_busy           <= 1'b1;
            timer_r              <= RST_CYCLES;
          end
        end
      end
      if (reset_busy && !sel_s_r[1]) begin
        serial_out_oe <= 1'b0;
      end
    end
  end
endmodule

// File: common/secreg_consts.vh
`ifndef SECREG_CONSTS_VH
`define SECREG_CONSTS_VH
`define OP_WR_LATCH_SET  8'h06
`define OP_SECREG_PROG   8'h42
`define OP_SECREG_READ   8'h48
`define OP_RESET_ENABLE  8'h66
`define OP_RESET         8'h99
`define OP_DISCOVERY     8'h5a
`define SECREG_COUNT     4
`define CLK_SYS_MHZ      100
`define PAGE_PROG_US     1100
`define PAGE_PROG_CYC    (`PAGE_PROG_US * `CLK_SYS_MHZ)
`define RST_REC_US       30
`define RST_REC_CYC      (`RST_REC_US * `CLK_SYS_MHZ)
`define DISC_SIG0        8'h53
`define DISC_SIG1        8'h46
`define DISC_SIG2        8'h44
`define DISC_SIG3        8'h50
`define DISC_MINOR       8'h06
`define DISC_MAJOR       8'h01
`define DISC_NPH         8'h01
`define DISC_UNUSED      8'hff
`define PH0_ID           8'h00
`define PH0_MINOR        8'h06
`define PH0_MAJOR        8'h01
`define PH0_LEN          8'h09
`define PH0_PTR          8'h30
`define PH1_MINOR        8'h00
`define PH1_MAJOR        8'h01
`define PH1_LEN          8'h03
`define PH1_PTR          8'h60
`define FIFO_DEPTH       8
`define FIFO_AW          3
`endif

// File: hw/byte_fifo.v
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_r != DEPTH);
  assign out_valid = (cnt_r != 0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem[rp_r];
  end

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
    if (reset) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// File: sim/spi_host.sv
module spi_host (
  input  wire  clk_sys,
  output logic sel_n,
  output logic sclk,
  output logic serial_in_line,
  input  wire  serial_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    serial_in_line = 1'b0;
  end
  // Four clk_sys cycles per half period make the 80 ns link clock
  task automatic open_frame;
    @(posedge clk_sys);
    sel_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Released data line flips so a stale level is never mistaken for data
  task automatic close_frame;
    repeat (4) @(posedge clk_sys);
    sel_n <= 1'b1;
    serial_in_line <= ~serial_in_line;
    repeat (20) @(posedge clk_sys);
  endtask
  // Output is taken late in the high phase, where it still stands
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in_line <= tx[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rx[i] = serial_out;
      @(posedge clk_sys);
      sclk <= 1'b0;
    end
  endtask
endmodule

// File: sim/secreg_cmd_asserts.sv
module secreg_cmd_asserts (
  input wire       clk_sys,
  input wire       reset,
  input wire       sel_n,
  input wire       sclk,
  input wire       serial_in_line,
  input wire       serial_out,
  input wire       serial_out_oe,
  input wire       secreg_lock_flag,
  input wire       write_latch_flag,
  input wire       op_in_progress_flag,
  input wire       suspend_flag,
  input wire [7:0] read_param_bits,
  input wire [7:0] continuous_read_bits,
  input wire [2:0] wrap_bits,
  input wire       reset_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_clears: assert property ($fell(reset) |-> !write_latch_flag && !reset_busy)
    else $error("Flags set after reset");
  a_oe_release: assert property ($rose(sel_n) |-> ##[1:5] !serial_out_oe)
    else $error("Output kept driven after select rise");
  a_recovery_no_cmd: assert property (reset_busy |-> !write_latch_flag)
    else $error("Command accepted during reset recovery");
  a_recovery_clears: assert property ($rose(reset_busy) |-> ##[0:3] (!write_latch_flag
    && !suspend_flag && wrap_bits == 3'h0 && read_param_bits == 8'h00
    && continuous_read_bits == 8'h00))
    else $error("Volatile state kept by reset");
  a_lock_blocks: assert property ($rose(op_in_progress_flag) && secreg_lock_flag |-> reset_busy)
    else $error("Program started while locked");
  a_start_select: assert property ($rose(op_in_progress_flag) |-> sel_n && $past(sel_n, 2))
    else $error("Busy rose inside a frame");
  a_latch_end: assert property ($fell(op_in_progress_flag) |-> !write_latch_flag)
    else $error("Write latch set at end of cycle");
  a_prog_latch: assert property ($rose(op_in_progress_flag) && !reset_busy |-> $past(write_latch_flag))
    else $error("Program started without write latch");
endmodule
bind secreg_cmd secreg_cmd_asserts i_secreg_cmd_asserts (
  .clk_sys(clk_sys), .reset(reset), .sel_n(sel_n), .sclk(sclk),
  .serial_in_line(serial_in_line), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .secreg_lock_flag(secreg_lock_flag), .write_latch_flag(write_latch_flag),
  .op_in_progress_flag(op_in_progress_flag), .suspend_flag(suspend_flag),
  .read_param_bits(read_param_bits), .continuous_read_bits(continuous_read_bits),
  .wrap_bits(wrap_bits), .reset_busy(reset_busy));

// File: sim/secreg_cmd_bench.sv
`include "secreg_consts.vh"
module secreg_cmd_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] maker_code = 8'h5a; // Arbitrary value
  logic       clk_sys;
  logic       reset;
  logic       lock;
  logic [7:0] rx;
  wire        sel_n, sclk, serial_in_line, serial_out, serial_out_oe;
  wire        write_latch_flag, op_in_progress_flag, suspend_flag, reset_busy;
  wire  [7:0] read_param_bits, continuous_read_bits;
  wire  [2:0] wrap_bits;
  int         miscompares;
  int         samples_checked;
  secreg_cmd #(.PROG_CYCLES(24'h00_0032), .VENDOR_ID(maker_code)) i_secreg_cmd (
    .clk_sys(clk_sys), .reset(reset), .sel_n(sel_n), .sclk(sclk),
    .serial_in_line(serial_in_line), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .secreg_lock_flag(lock), .write_latch_flag(write_latch_flag),
    .op_in_progress_flag(op_in_progress_flag), .suspend_flag(suspend_flag),
    .read_param_bits(read_param_bits), .continuous_read_bits(continuous_read_bits),
    .wrap_bits(wrap_bits), .reset_busy(reset_busy));
  spi_host i_spi_host (.clk_sys(clk_sys), .sel_n(sel_n), .sclk(sclk),
    .serial_in_line(serial_in_line), .serial_out(serial_out));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic op(input logic [7:0] code);
    i_spi_host.open_frame();
    i_spi_host.xfer(code, rx);
    i_spi_host.close_frame();
  endtask
  task automatic head(input logic [7:0] code, input logic [15:0] a);
    i_spi_host.open_frame();
    i_spi_host.xfer(code, rx);
    i_spi_host.xfer(8'h00, rx);
    i_spi_host.xfer(a[15:8], rx);
    i_spi_host.xfer(a[7:0], rx);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 5000 && op_in_progress_flag !== 1'b0; i++) @(posedge clk_sys);
    if (op_in_progress_flag !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // Bytes go out from the top of d; busy tells whether the device may accept
  task automatic prog(input logic [15:0] a, input logic [15:0] d, input int n, input logic busy);
    op(`OP_WR_LATCH_SET);
    check(write_latch_flag, 8'h01);
    head(`OP_SECREG_PROG, a);
    for (int i = 0; i < n; i++) i_spi_host.xfer(d[15-8*i -: 8], rx);
    i_spi_host.close_frame();
    check(op_in_progress_flag, busy);
    wait_idle();
    check(write_latch_flag, !busy);
  endtask
  // Expected bytes are left aligned in e
  task automatic rd(input logic [7:0] code, input logic [15:0] a, input logic [63:0] e,
                    input int n);
    head(code, a);
    i_spi_host.xfer(8'h00, rx);
    for (int i = 0; i < n; i++) begin
      i_spi_host.xfer(8'h00, rx);
      check(rx, e[63-8*i -: 8]);
    end
    i_spi_host.close_frame();
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    lock = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    check(write_latch_flag, 8'h00);
    $display("Done: reset state");
    prog(16'h03fe, 16'ha55a, 2, 1'b1);
    prog(16'h0300, 16'h3c00, 1, 1'b1);
    prog(16'h0100, 16'h7700, 1, 1'b1);
    $display("Done: program");
    rd(`OP_SECREG_READ, 16'h03fe, 64'ha55a_3c00_0000_0000, 3);
    rd(`OP_SECREG_READ, 16'h0100, 64'h7700_0000_0000_0000, 1);
    $display("Done: read and wrap");
    @(posedge clk_sys);
    lock <= 1'b1;
    prog(16'h03fe, 16'h0000, 1, 1'b0);
    rd(`OP_SECREG_READ, 16'h03fe, 64'ha500_0000_0000_0000, 1);
    @(posedge clk_sys);
    lock <= 1'b0;
    $display("Done: lock");
    op(`OP_RESET);
    check(reset_busy, 8'h00);
    check(op_in_progress_flag, 8'h00);
    op(`OP_RESET_ENABLE);
    op(`OP_RESET);
    check(reset_busy, 8'h01);
    check(write_latch_flag, 8'h00);
    op(`OP_WR_LATCH_SET);
    check(write_latch_flag, 8'h00);
    wait_idle();
    check(reset_busy, 8'h00);
    $display("Done: software reset");
    rd(`OP_DISCOVERY, 16'h0000, 64'h5346_4450_0601_01ff, 8);
    rd(`OP_DISCOVERY, 16'h0008, 64'h0006_0109_3000_00ff, 8);
    rd(`OP_DISCOVERY, 16'h0010, {maker_code, 56'h00_0103_6000_00ff}, 8);
    $display("Done: discovery header");
    tally_and_finish();
  end
endmodule
